/* File: shared/eeprom_param_pkg.sv */
package eeprom_param_pkg;

	// ----------------------------------------------------------------
	// word geometry
	// ----------------------------------------------------------------
	localparam int WORD_DATA_W = 24;
	localparam int WORD_CHECK_W = 6;
	localparam int WORD_W = 30;
	localparam int EE_ADDR_W = 6;
	localparam int APB_ADDR_W = 8;
	localparam int NUM_WORDS = 24;

	// stored bit index of each data bit D0..D23 and check bit C0..C5
	localparam int DATA_POS [WORD_DATA_W] = '{3, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 17, 18, 19, 20, 21,
		22, 23, 24, 25, 26, 27, 28, 29};
	localparam int CHECK_POS [WORD_CHECK_W] = '{0, 1, 2, 4, 8, 16};
	// check-bit columns of each data bit; distinct, weight of two or more
	localparam logic [5:0] DATA_COL [WORD_DATA_W] = '{6'h03, 6'h05, 6'h06, 6'h07, 6'h09, 6'h0A, 6'h0B,
		6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
		6'h1A, 6'h1B, 6'h1C, 6'h1D};

	// ----------------------------------------------------------------
	// word addresses (register index, byte address is four times it)
	// ----------------------------------------------------------------
	localparam logic [5:0] FIRST_WORD = 6'h08;
	localparam logic [5:0] LAST_WORD = 6'h1F;
	localparam logic [5:0] WORD_SECOND_ORDER = 6'h08;
	localparam logic [5:0] WORD_FIRST_ORDER = 6'h09;
	localparam logic [5:0] WORD_GAIN_MULT = 6'h0A;
	localparam logic [5:0] WORD_LIN_FIRST = 6'h0B;
	localparam logic [5:0] WORD_LIN_LAST = 6'h1B;
	localparam logic [5:0] WORD_CLAMP_MODE = 6'h1C;
	localparam logic [5:0] WORD_QUIESCENT = 6'h1D;
	localparam logic [5:0] WORD_PROTOCOL = 6'h1E;
	localparam logic [5:0] WORD_SCRATCH = 6'h1F;
	localparam logic [5:0] STATUS_IDX = 6'h20;
	localparam logic [5:0] LIN_POS_MAX = 6'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SO_HOT_LSB = 15, SO_HOT_W = 9;
	localparam int SO_COLD_LSB = 6, SO_COLD_W = 9;
	localparam int COARSE_LSB = 2, COARSE_W = 4;
	localparam int FO_HOT_LSB = 16, FO_HOT_W = 8;
	localparam int FO_COLD_LSB = 8, FO_COLD_W = 8;
	localparam int FO_OFS_LSB = 0, FO_OFS_W = 8;
	localparam int GAIN_MULT_LSB = 0, GAIN_MULT_W = 12;
	localparam int LIN_ODD_LSB = 12, LIN_EVEN_LSB = 0, LIN_COEFF_W = 12;
	localparam int LIN_LOADED_BIT = 23, OUT_INV_BIT = 22, LIN_IN_INV_BIT = 21;
	localparam int CLAMP_HI_LSB = 18, CLAMP_HI_W = 6;
	localparam int CLAMP_LO_LSB = 12, CLAMP_LO_W = 6;
	localparam int OV_SEL_BIT = 10, LV_OFF_BIT = 9, MODE_BIT = 3;
	localparam int COFS_LSB = 4, COFS_W = 5;
	localparam int FBW_LSB = 0, FBW_W = 3;
	localparam int QTRIM_LSB = 0, QTRIM_W = 12;
	localparam int LOCK_BIT = 23;
	localparam int PROTO_CFG_W = 18, PWM_CFG_W = 4;
	localparam int TICK_LSB = 11, TICK_W = 7;
	localparam int FIXINT_LSB = 9, FIXINT_W = 2, FIXASG_BIT = 8;
	localparam int PAUSE_LSB = 5, PAUSE_W = 3;
	localparam int NIBFMT_LSB = 3, NIBFMT_W = 2, ERRST_BIT = 2;
	localparam int SERFMT_LSB = 0, SERFMT_W = 2;
	localparam int PWMCAL_BIT = 3, CARRIER_LSB = 0, CARRIER_W = 3;

	// status word layout
	localparam int ST_LOAD_DONE_BIT = 0, ST_LOCK_BIT = 1, ST_LIN_LOADED_BIT = 2, ST_MODE_BIT = 3;
	localparam int ST_CORR_LSB = 8, ST_UNCORR_LSB = 16, CNT_W = 8;
	localparam logic [7:0] CNT_MAX = 8'hFF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ARB_IDLE = 1'b0,
		ARB_BUSY = 1'b1
	} arb_state_t;

	typedef enum logic [1:0] {
		CL_STATIC = 2'b00,
		CL_TEMP = 2'b01,
		CL_LIN = 2'b10,
		CL_SERIAL = 2'b11
	} client_t;

endpackage

/* File: rtl/ecc_word_codec.sv */
`timescale 1ns/1ps
module ecc_word_codec
	import eeprom_param_pkg::*;
(
	// encode side
	input wire logic [WORD_DATA_W-1:0] enc_data,
	output logic [WORD_W-1:0] enc_word,
	// decode side
	input wire logic [WORD_W-1:0] dec_word,
	output logic [WORD_DATA_W-1:0] dec_data,
	output logic dec_corrected,
	output logic dec_uncorrectable
);

	function automatic logic [WORD_CHECK_W-1:0] calc_check(input logic [WORD_DATA_W-1:0] d);
		logic [WORD_CHECK_W-1:0] c;
		c = '0;
		for (int i = 0; i < WORD_DATA_W; i++) begin
			if (d[i]) begin
				c = c ^ DATA_COL[i];
			end
		end
		return c;
	endfunction

	logic [WORD_CHECK_W-1:0] enc_check;
	logic [WORD_DATA_W-1:0] raw_data;
	logic [WORD_CHECK_W-1:0] raw_check;
	logic [WORD_CHECK_W-1:0] syndrome;
	logic data_hit;

	// ----------------------------------------------------------------
	// encode: 24 data bits plus 6 check bits in a 30-bit word
	// ----------------------------------------------------------------
	always_comb begin
		enc_check = calc_check(enc_data);
		enc_word = '0;
		for (int i = 0; i < WORD_DATA_W; i++) begin
			enc_word[DATA_POS[i]] = enc_data[i];
		end
		for (int k = 0; k < WORD_CHECK_W; k++) begin
			enc_word[CHECK_POS[k]] = enc_check[k];
		end
	end

	// ----------------------------------------------------------------
	// decode with single-bit correction
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < WORD_DATA_W; i++) begin
			raw_data[i] = dec_word[DATA_POS[i]];
		end
		for (int k = 0; k < WORD_CHECK_W; k++) begin
			raw_check[k] = dec_word[CHECK_POS[k]];
		end
		syndrome = raw_check ^ calc_check(raw_data);
		dec_data = raw_data;
		data_hit = 1'b0;
		for (int i = 0; i < WORD_DATA_W; i++) begin
			if (syndrome == DATA_COL[i]) begin
				dec_data[i] = ~raw_data[i];
				data_hit = 1'b1;
			end
		end
		// a one-hot syndrome is a flipped check bit: data already good
		dec_corrected = data_hit || ((syndrome != '0) && ($countones(syndrome) == 1));
		dec_uncorrectable = (syndrome != '0) && !dec_corrected;
	end

endmodule // ecc_word_codec

/* File: rtl/eeprom_arbiter_and_param_map.sv */
// Summary of operation
// - fixed priority: static, temperature, linearization, serial
// - words are 30 bits: 24 data, 6 check
// - stored bit order of data and check bits
// - unprogrammed fields read as zero
// - mode bit selects sent or pwm meaning
// - sent mode configuration field decode
// - pwm mode calibration and carrier decode
// - lock bit permanently refuses programming access
// - linearization coefficients in odd/even halves
// - table loaded flag output
// - output and linearization input inversion flags
// - second-order gain coefficients hot and cold
// - first-order gain and offset drift coefficients
// - coarse gain range and gain multiplier
// - clamps, voltage flags, coarse offset, bandwidth
// - quiescent duty trim field
`timescale 1ns/1ps
module eeprom_arbiter_and_param_map
	import eeprom_param_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb slave (serial programming path)
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// temperature compensation client
	input wire logic tc_req,
	input wire logic [EE_ADDR_W-1:0] tc_addr,
	output logic tc_ack,
	output logic [WORD_DATA_W-1:0] tc_rdata,
	// linearization client
	input wire logic lin_req,
	input wire logic [5:0] lin_pos,
	output logic lin_ack,
	output logic [LIN_COEFF_W-1:0] lin_coeff,
	// nonvolatile array port
	output logic ee_req,
	output logic ee_we,
	output logic [EE_ADDR_W-1:0] ee_addr,
	output logic [WORD_W-1:0] ee_wdata,
	input wire logic [WORD_W-1:0] ee_rdata,
	input wire logic ee_ack,
	// decoded parameters
	output logic params_valid,
	output logic [SO_HOT_W-1:0] second_order_gain_tc_hot,
	output logic [SO_COLD_W-1:0] second_order_gain_tc_cold,
	output logic [COARSE_W-1:0] coarse_gain_range,
	output logic [FO_HOT_W-1:0] first_order_gain_tc_hot,
	output logic [FO_COLD_W-1:0] first_order_gain_tc_cold,
	output logic [FO_OFS_W-1:0] first_order_offset_drift,
	output logic [GAIN_MULT_W-1:0] gain_multiplier,
	output logic lin_table_loaded,
	output logic output_invert,
	output logic lin_input_invert,
	output logic [CLAMP_HI_W-1:0] clamp_upper,
	output logic [CLAMP_LO_W-1:0] clamp_lower,
	output logic overvoltage_threshold_select,
	output logic low_voltage_detect_off,
	output logic [COFS_W-1:0] coarse_offset_trim,
	output logic output_mode_pwm,
	output logic [FBW_W-1:0] filter_bandwidth_select,
	output logic [QTRIM_W-1:0] quiescent_duty_trim,
	output logic permanent_lock_bit,
	// sent mode fields, zero in pwm mode
	output logic [TICK_W-1:0] tick_rate_coeff,
	output logic [FIXINT_W-1:0] fixed_state_interval,
	output logic fixed_state_assignment,
	output logic [PAUSE_W-1:0] pause_frame_rate_select,
	output logic [NIBFMT_W-1:0] data_nibble_format,
	output logic error_status_bit,
	output logic [SERFMT_W-1:0] serial_message_format,
	// pwm mode fields, zero in sent mode
	output logic pwm_calibrate_en,
	output logic [CARRIER_W-1:0] carrier_frequency_select
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		arb_state_t st;
		client_t grant;
		logic [4:0] load_idx;
		logic load_done;
		logic [NUM_WORDS-1:0][WORD_DATA_W-1:0] shadow;
		logic ee_req;
		logic ee_we;
		logic [EE_ADDR_W-1:0] ee_addr;
		logic [WORD_W-1:0] ee_wdata;
		logic tc_ack;
		logic [WORD_DATA_W-1:0] tc_rdata;
		logic lin_ack;
		logic lin_odd;
		logic [LIN_COEFF_W-1:0] lin_coeff;
		logic apb_pend;
		logic apb_we;
		logic [EE_ADDR_W-1:0] apb_idx;
		logic [WORD_DATA_W-1:0] apb_wdata;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [CNT_W-1:0] corr_cnt;
		logic [CNT_W-1:0] uncorr_cnt;
		logic [PROTO_CFG_W-1:0] sent_cfg;
		logic [PWM_CFG_W-1:0] pwm_cfg;
	} ctl_t;

	localparam ctl_t CTL_RESET = '0;

	ctl_t ctl_ff;
	ctl_t nxt_ctl;

	function automatic logic [4:0] word_slot(input logic [EE_ADDR_W-1:0] idx);
		return 5'(idx - FIRST_WORD);
	endfunction

	// word holding linearization position pos, clamped to the last position
	function automatic logic [EE_ADDR_W-1:0] lin_word(input logic [5:0] pos);
		logic [5:0] p;
		p = (pos > LIN_POS_MAX) ? LIN_POS_MAX : pos;
		return 6'(WORD_LIN_FIRST + (p >> 1));
	endfunction

	// ----------------------------------------------------------------
	// codec
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] enc_word;
	logic [WORD_DATA_W-1:0] dec_data;
	logic dec_corrected;
	logic dec_uncorrectable;

	ecc_word_codec ecc_word_codec_i (
		.enc_data(ctl_ff.apb_wdata),
		.enc_word(enc_word),
		.dec_word(ee_rdata),
		.dec_data(dec_data),
		.dec_corrected(dec_corrected),
		.dec_uncorrectable(dec_uncorrectable)
	);

	// ----------------------------------------------------------------
	// bus decode helpers
	// ----------------------------------------------------------------
	logic [EE_ADDR_W-1:0] bus_idx;
	logic bus_mapped;
	logic locked;
	logic [31:0] status_word;
	logic [WORD_DATA_W-1:0] cfg_word;
	logic mode_pwm;

	assign bus_idx = paddr[APB_ADDR_W-1:2];
	assign bus_mapped = (paddr[1:0] == 2'b00) && (bus_idx >= FIRST_WORD) && (bus_idx <= LAST_WORD);
	assign locked = ctl_ff.shadow[word_slot(WORD_PROTOCOL)][LOCK_BIT];

	always_comb begin
		status_word = '0;
		status_word[ST_LOAD_DONE_BIT] = ctl_ff.load_done;
		status_word[ST_LOCK_BIT] = locked;
		status_word[ST_LIN_LOADED_BIT] = ctl_ff.shadow[word_slot(WORD_LIN_LAST)][LIN_LOADED_BIT];
		status_word[ST_MODE_BIT] = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][MODE_BIT];
		status_word[ST_CORR_LSB +: CNT_W] = ctl_ff.corr_cnt;
		status_word[ST_UNCORR_LSB +: CNT_W] = ctl_ff.uncorr_cnt;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ctl = ctl_ff;
		nxt_ctl.tc_ack = 1'b0;
		nxt_ctl.lin_ack = 1'b0;
		nxt_ctl.pready = 1'b0;
		nxt_ctl.pslverr = 1'b0;

		// take an apb access phase once the parameters are loaded
		if (psel && penable && !ctl_ff.pready && !ctl_ff.apb_pend && ctl_ff.load_done) begin
			if (locked) begin
				nxt_ctl.pready = 1'b1;
				nxt_ctl.pslverr = 1'b1;
				nxt_ctl.prdata = '0;
			end else if (paddr[1:0] == 2'b00 && bus_idx == STATUS_IDX) begin
				nxt_ctl.pready = 1'b1;
				nxt_ctl.pslverr = pwrite;
				nxt_ctl.prdata = pwrite ? 32'h0000_0000 : status_word;
			end else if (!bus_mapped) begin
				nxt_ctl.pready = 1'b1;
				nxt_ctl.pslverr = 1'b1;
				nxt_ctl.prdata = '0;
			end else begin
				nxt_ctl.apb_pend = 1'b1;
				nxt_ctl.apb_we = pwrite;
				nxt_ctl.apb_idx = bus_idx;
				nxt_ctl.apb_wdata = pwdata[WORD_DATA_W-1:0];
			end
		end

		case (ctl_ff.st)
			ARB_IDLE: begin
				if (!ctl_ff.load_done) begin
					nxt_ctl.grant = CL_STATIC;
					nxt_ctl.ee_addr = 6'(FIRST_WORD + 6'(ctl_ff.load_idx));
					nxt_ctl.ee_we = 1'b0;
					nxt_ctl.ee_req = 1'b1;
					nxt_ctl.st = ARB_BUSY;
				end else if (tc_req && !ctl_ff.tc_ack) begin
					nxt_ctl.grant = CL_TEMP;
					nxt_ctl.ee_addr = tc_addr;
					nxt_ctl.ee_we = 1'b0;
					nxt_ctl.ee_req = 1'b1;
					nxt_ctl.st = ARB_BUSY;
				end else if (lin_req && !ctl_ff.lin_ack) begin
					nxt_ctl.grant = CL_LIN;
					nxt_ctl.ee_addr = lin_word(lin_pos);
					nxt_ctl.lin_odd = (lin_pos <= LIN_POS_MAX) && lin_pos[0];
					nxt_ctl.ee_we = 1'b0;
					nxt_ctl.ee_req = 1'b1;
					nxt_ctl.st = ARB_BUSY;
				end else if (ctl_ff.apb_pend) begin
					nxt_ctl.grant = CL_SERIAL;
					nxt_ctl.ee_addr = ctl_ff.apb_idx;
					nxt_ctl.ee_we = ctl_ff.apb_we;
					nxt_ctl.ee_wdata = enc_word;
					nxt_ctl.ee_req = 1'b1;
					nxt_ctl.st = ARB_BUSY;
				end
			end
			ARB_BUSY: begin
				// grant and request stay fixed until the array answers
				if (ee_ack) begin
					nxt_ctl.ee_req = 1'b0;
					nxt_ctl.ee_we = 1'b0;
					nxt_ctl.st = ARB_IDLE;
					if (!ctl_ff.ee_we && dec_corrected && ctl_ff.corr_cnt != CNT_MAX) begin
						nxt_ctl.corr_cnt = ctl_ff.corr_cnt + 8'h01;
					end
					if (!ctl_ff.ee_we && dec_uncorrectable && ctl_ff.uncorr_cnt != CNT_MAX) begin
						nxt_ctl.uncorr_cnt = ctl_ff.uncorr_cnt + 8'h01;
					end
					case (ctl_ff.grant)
						CL_STATIC: begin
							nxt_ctl.shadow[ctl_ff.load_idx] = dec_data;
							if (ctl_ff.load_idx == 5'(NUM_WORDS - 1)) begin
								nxt_ctl.load_done = 1'b1;
							end else begin
								nxt_ctl.load_idx = ctl_ff.load_idx + 5'h01;
							end
						end
						CL_TEMP: begin
							nxt_ctl.tc_rdata = dec_data;
							nxt_ctl.tc_ack = 1'b1;
						end
						CL_LIN: begin
							nxt_ctl.lin_coeff = ctl_ff.lin_odd ? dec_data[LIN_ODD_LSB +: LIN_COEFF_W] :
								dec_data[LIN_EVEN_LSB +: LIN_COEFF_W];
							nxt_ctl.lin_ack = 1'b1;
						end
						CL_SERIAL: begin
							nxt_ctl.apb_pend = 1'b0;
							nxt_ctl.pready = 1'b1;
							if (ctl_ff.apb_we) begin
								nxt_ctl.shadow[word_slot(ctl_ff.apb_idx)] = ctl_ff.apb_wdata;
								nxt_ctl.prdata = '0;
							end else begin
								nxt_ctl.prdata = {8'h00, dec_data};
							end
						end
						default: begin
							nxt_ctl.st = ARB_IDLE;
						end
					endcase
				end
			end
			default: begin
				nxt_ctl.st = ARB_IDLE;
			end
		endcase

		// protocol-dependent view of the configuration word
		cfg_word = nxt_ctl.shadow[word_slot(WORD_PROTOCOL)];
		mode_pwm = nxt_ctl.shadow[word_slot(WORD_CLAMP_MODE)][MODE_BIT];
		nxt_ctl.sent_cfg = mode_pwm ? '0 : cfg_word[PROTO_CFG_W-1:0];
		nxt_ctl.pwm_cfg = mode_pwm ? cfg_word[PWM_CFG_W-1:0] : '0;
	end

	// shadow and all fields start at zero until loaded
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_ff <= CTL_RESET;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = ctl_ff.prdata;
	assign pready = ctl_ff.pready;
	assign pslverr = ctl_ff.pslverr;
	assign tc_ack = ctl_ff.tc_ack;
	assign tc_rdata = ctl_ff.tc_rdata;
	assign lin_ack = ctl_ff.lin_ack;
	assign lin_coeff = ctl_ff.lin_coeff;
	assign ee_req = ctl_ff.ee_req;
	assign ee_we = ctl_ff.ee_we;
	assign ee_addr = ctl_ff.ee_addr;
	assign ee_wdata = ctl_ff.ee_wdata;
	assign params_valid = ctl_ff.load_done;

	assign second_order_gain_tc_hot = ctl_ff.shadow[word_slot(WORD_SECOND_ORDER)][SO_HOT_LSB +: SO_HOT_W];
	assign second_order_gain_tc_cold = ctl_ff.shadow[word_slot(WORD_SECOND_ORDER)][SO_COLD_LSB +: SO_COLD_W];
	assign coarse_gain_range = ctl_ff.shadow[word_slot(WORD_SECOND_ORDER)][COARSE_LSB +: COARSE_W];
	assign first_order_gain_tc_hot = ctl_ff.shadow[word_slot(WORD_FIRST_ORDER)][FO_HOT_LSB +: FO_HOT_W];
	assign first_order_gain_tc_cold = ctl_ff.shadow[word_slot(WORD_FIRST_ORDER)][FO_COLD_LSB +: FO_COLD_W];
	assign first_order_offset_drift = ctl_ff.shadow[word_slot(WORD_FIRST_ORDER)][FO_OFS_LSB +: FO_OFS_W];
	assign gain_multiplier = ctl_ff.shadow[word_slot(WORD_GAIN_MULT)][GAIN_MULT_LSB +: GAIN_MULT_W];
	assign lin_table_loaded = ctl_ff.shadow[word_slot(WORD_LIN_LAST)][LIN_LOADED_BIT];
	assign output_invert = ctl_ff.shadow[word_slot(WORD_LIN_LAST)][OUT_INV_BIT];
	assign lin_input_invert = ctl_ff.shadow[word_slot(WORD_LIN_LAST)][LIN_IN_INV_BIT];
	assign clamp_upper = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][CLAMP_HI_LSB +: CLAMP_HI_W];
	assign clamp_lower = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][CLAMP_LO_LSB +: CLAMP_LO_W];
	assign overvoltage_threshold_select = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][OV_SEL_BIT];
	assign low_voltage_detect_off = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][LV_OFF_BIT];
	assign coarse_offset_trim = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][COFS_LSB +: COFS_W];
	assign output_mode_pwm = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][MODE_BIT];
	assign filter_bandwidth_select = ctl_ff.shadow[word_slot(WORD_CLAMP_MODE)][FBW_LSB +: FBW_W];
	assign quiescent_duty_trim = ctl_ff.shadow[word_slot(WORD_QUIESCENT)][QTRIM_LSB +: QTRIM_W];
	assign permanent_lock_bit = ctl_ff.shadow[word_slot(WORD_PROTOCOL)][LOCK_BIT];

	assign tick_rate_coeff = ctl_ff.sent_cfg[TICK_LSB +: TICK_W];
	assign fixed_state_interval = ctl_ff.sent_cfg[FIXINT_LSB +: FIXINT_W];
	assign fixed_state_assignment = ctl_ff.sent_cfg[FIXASG_BIT];
	assign pause_frame_rate_select = ctl_ff.sent_cfg[PAUSE_LSB +: PAUSE_W];
	assign data_nibble_format = ctl_ff.sent_cfg[NIBFMT_LSB +: NIBFMT_W];
	assign error_status_bit = ctl_ff.sent_cfg[ERRST_BIT];
	assign serial_message_format = ctl_ff.sent_cfg[SERFMT_LSB +: SERFMT_W];
	assign pwm_calibrate_en = ctl_ff.pwm_cfg[PWMCAL_BIT];
	assign carrier_frequency_select = ctl_ff.pwm_cfg[CARRIER_LSB +: CARRIER_W];

endmodule // eeprom_arbiter_and_param_map

/* File: tb/eeprom_arbiter_monitor.sv */
`timescale 1ns/1ps
module eeprom_arbiter_monitor
	import eeprom_param_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// handshakes
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ee_req,
	input wire logic ee_we,
	input wire logic ee_ack,
	input wire logic [EE_ADDR_W-1:0] ee_addr,
	input wire logic tc_ack,
	input wire logic lin_ack,
	// decoded state
	input wire logic params_valid,
	input wire logic permanent_lock_bit,
	input wire logic output_mode_pwm,
	input wire logic pwm_calibrate_en,
	input wire logic [CARRIER_W-1:0] carrier_frequency_select,
	input wire logic [TICK_W-1:0] tick_rate_coeff
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_array_hold: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr) && $stable(ee_we))
		else $error("array request not held");
	a_array_release: assert property (ee_req && ee_ack |=> !ee_req)
		else $error("array request kept after answer");
	a_one_grant: assert property (tc_ack || lin_ack |-> $past(ee_ack) && !(tc_ack && lin_ack))
		else $error("client answer without array answer");
	a_load_first: assert property (!params_valid |-> !pready && !tc_ack && !lin_ack)
		else $error("client served before static load");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_qual: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_lock_refuse: assert property (pready && permanent_lock_bit && $past(permanent_lock_bit) |-> pslverr)
		else $error("access accepted while locked");
	a_sent_quiet: assert property (!output_mode_pwm |-> !pwm_calibrate_en && carrier_frequency_select == 3'h0)
		else $error("pwm fields live in sent mode");
	a_pwm_quiet: assert property (output_mode_pwm |-> tick_rate_coeff == 7'h00)
		else $error("sent fields live in pwm mode");
	cover property (tc_ack);
	cover property (lin_ack);
	cover property (pready && pslverr);
endmodule // eeprom_arbiter_monitor

bind eeprom_arbiter_and_param_map eeprom_arbiter_monitor eeprom_arbiter_monitor_i (.*);

/* File: tb/ee_array_model.sv */
`timescale 1ns/1ps
module ee_array_model
	import eeprom_param_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// array port
	input wire logic ee_req,
	input wire logic ee_we,
	input wire logic [EE_ADDR_W-1:0] ee_addr,
	input wire logic [WORD_W-1:0] ee_wdata,
	output logic [WORD_W-1:0] ee_rdata,
	output logic ee_ack,
	// answer delay in cycles
	input wire logic [1:0] slow
);
	logic [WORD_W-1:0] mem [64] = '{default: '0};
	logic [1:0] cnt = 2'h0;
	initial ee_rdata = '0;
	initial ee_ack = 1'b0;
	always @(posedge sys_clk) begin
		ee_ack <= 1'b0;
		// read data inverts every cycle outside an answer
		ee_rdata <= ~ee_rdata;
		if (rst)
			cnt <= 2'h0;
		else if (ee_req && !ee_ack && cnt < slow)
			cnt <= cnt + 2'h1;
		else if (ee_req && !ee_ack) begin
			cnt <= 2'h0;
			ee_ack <= 1'b1;
			if (ee_we)
				mem[ee_addr] <= ee_wdata;
			else
				ee_rdata <= mem[ee_addr];
		end
	end
endmodule // ee_array_model

/* File: tb/eeprom_arbiter_and_param_map_test.sv */
`timescale 1ns/1ps
module eeprom_arbiter_and_param_map_test
	import eeprom_param_pkg::*;
;
	localparam logic [23:0] P = 24'h5A_C396, Q = 24'h25_3C69, D = 24'h9E_174B;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tc_req = 0, lin_req = 0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [5:0] tc_addr = 6'h00, lin_pos = 6'h00, ee_addr, ck;
	logic [1:0] slow = 2'h0;
	logic pready, pslverr, tc_ack, lin_ack, ee_req, ee_we, ee_ack, params_valid, lin_table_loaded, output_invert;
	logic lin_input_invert, overvoltage_threshold_select, low_voltage_detect_off, output_mode_pwm, permanent_lock_bit;
	logic fixed_state_assignment, error_status_bit, pwm_calibrate_en;
	logic [29:0] ee_wdata, ee_rdata, mw;
	logic [23:0] tc_rdata, r, rt;
	logic [11:0] lin_coeff, gain_multiplier, quiescent_duty_trim, c;
	logic [8:0] second_order_gain_tc_hot, second_order_gain_tc_cold;
	logic [7:0] first_order_gain_tc_hot, first_order_gain_tc_cold, first_order_offset_drift;
	logic [5:0] clamp_upper, clamp_lower;
	logic [4:0] coarse_offset_trim;
	logic [3:0] coarse_gain_range;
	logic [6:0] tick_rate_coeff;
	logic [2:0] filter_bandwidth_select, pause_frame_rate_select, carrier_frequency_select;
	logic [1:0] fixed_state_interval, data_nibble_format, serial_message_format;
	logic [7:0] wa [7] = '{8'h20, 8'h24, 8'h28, 8'h6C, 8'h70, 8'h74, 8'h78};
	logic [7:0] bad [3] = '{8'h84, 8'h22, 8'h1C};
	int miscompares = 0, num_checks = 0;
	time t1, t2, t3;
	assign mw = ee_array_model_i.mem[31];
	eeprom_arbiter_and_param_map eeprom_arbiter_and_param_map_i (.*);
	ee_array_model ee_array_model_i (.*);
	initial forever #10 sys_clk = ~sys_clk;
	// ----
	// access tasks
	// ----
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value at time %0t: got %h, expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {8'h00, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata[23:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tcr(input logic [5:0] a);
		@(posedge sys_clk);
		tc_req <= 1'b1;
		tc_addr <= a;
		do @(posedge sys_clk); while (tc_ack !== 1'b1);
		rt = tc_rdata;
		tc_req <= 1'b0;
	endtask
	task automatic lcr(input logic [5:0] p);
		@(posedge sys_clk);
		lin_req <= 1'b1;
		lin_pos <= p;
		do @(posedge sys_clk); while (lin_ack !== 1'b1);
		c = lin_coeff;
		lin_req <= 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		tcr(6'h1E);
		chk({params_valid, rt}, {1'b1, 24'h00_0000});
		chk({clamp_upper, gain_multiplier, quiescent_duty_trim, permanent_lock_bit}, 0);
		for (int i = 8; i < 32; i++) begin
			apb(1'b0, 8'(i * 4), 24'h00_0000);
			chk({e, r}, 0);
		end
		$display("test unprogrammed done");
		for (int k = 0; k < 17; k++) apb(1'b1, 8'(8'h2C + k * 4), {12'(2 * k + 1), 12'(2 * k)});
		for (int k = 0; k < 34; k++) begin
			lcr(6'(k));
			chk(c, (k > 32) ? 32 : k);
		end
		slow <= 2'h3;
		fork
			begin tcr(6'h0B); t1 = $time; end
			begin lcr(6'h07); t2 = $time; end
			begin apb(1'b0, 8'h2C, 24'h00_0000); t3 = $time; end
		join
		slow <= 2'h0;
		chk({t1 < t2, t2 < t3, c}, {2'b11, 12'h007});
		chk(rt, 24'h00_1000);
		$display("test linearization and priority done");
		apb(1'b1, 8'h7C, D);
		ck = 6'h00;
		for (int j = 0; j < 24; j++) ck ^= DATA_COL[j] & {6{D[j]}};
		chk({mw[29:17], mw[15], mw[3]}, {D[23:11], D[10], D[0]});
		chk({mw[16], mw[8], mw[4], mw[2:0]}, {ck[5], ck[4], ck[3], ck[2:0]});
		ee_array_model_i.mem[31][20] ^= 1'b1;
		tcr(6'h1F);
		chk(rt, D);
		ee_array_model_i.mem[31][20] ^= 1'b1;
		ee_array_model_i.mem[31][16] ^= 1'b1;
		apb(1'b0, 8'h7C, 24'h00_0000);
		chk(r, D);
		ee_array_model_i.mem[31][20] ^= 1'b1;
		tcr(6'h1F);
		chk(rt, D ^ 24'h00_4000);
		ee_array_model_i.mem[31][20] ^= 1'b1;
		$display("test error correction done");
		foreach (wa[i]) apb(1'b1, wa[i], P);
		chk({second_order_gain_tc_hot, second_order_gain_tc_cold, coarse_gain_range}, P[23:2]);
		chk({first_order_gain_tc_hot, first_order_gain_tc_cold, first_order_offset_drift}, P);
		chk({gain_multiplier, quiescent_duty_trim}, {P[11:0], P[11:0]});
		chk({clamp_upper, clamp_lower, overvoltage_threshold_select, low_voltage_detect_off, coarse_offset_trim,
			output_mode_pwm, filter_bandwidth_select}, {P[23:12], P[10:0]});
		chk({tick_rate_coeff, fixed_state_interval, fixed_state_assignment, pause_frame_rate_select, data_nibble_format,
			error_status_bit, serial_message_format, pwm_calibrate_en, carrier_frequency_select}, {P[17:0], 4'h0});
		chk({lin_table_loaded, output_invert, lin_input_invert}, P[23:21]);
		apb(1'b0, 8'h80, 24'h00_0000);
		chk({e, r}, {1'b0, 24'h01_0201});
		apb(1'b1, 8'h70, Q);
		apb(1'b1, 8'h78, Q);
		chk({output_mode_pwm, tick_rate_coeff, pwm_calibrate_en, carrier_frequency_select}, {1'b1, 7'h00, Q[3:0]});
		$display("test parameter decode done");
		foreach (bad[i]) begin
			apb(1'b0, bad[i], 24'h00_0000);
			chk({e, r}, {1'b1, 24'h00_0000});
		end
		apb(1'b1, 8'h80, 24'hFF_FFFF);
		chk(e, 1'b1);
		apb(1'b1, 8'h78, 24'h80_0000);
		chk({e, permanent_lock_bit}, 2'b01);
		apb(1'b0, 8'h80, 24'h00_0000);
		chk({e, r}, {1'b1, 24'h00_0000});
		apb(1'b1, 8'h7C, 24'h00_0000);
		chk({e, mw[29:17]}, {1'b1, D[23:11]});
		rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		apb(1'b0, 8'h80, 24'h00_0000);
		chk({e, r, permanent_lock_bit}, {1'b1, 24'h00_0000, 1'b1});
		$display("test refusal and lock done");
		tally_and_finish();
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule // eeprom_arbiter_and_param_map_test
